// file: jtag_sel_pkg.sv
package jtag_sel_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int IR_W       = 8;
    localparam int DR_W       = 32;
    localparam int ADDR_W     = 12;
    localparam int ID_CNT_W   = 3;
    localparam int TMS_CNT_W  = 3;

    // ------------------------------------------------------------------
    // instruction codes
    // ------------------------------------------------------------------
    localparam logic [IR_W-1:0] IR_BULK_ERASE = 8'h03;
    localparam logic [IR_W-1:0] IR_BYPASS     = 8'hFF;
    localparam logic [IR_W-1:0] IR_IDCODE     = 8'h16;
    localparam logic [IR_W-1:0] IR_PROG_CFG   = 8'h21;
    localparam logic [IR_W-1:0] IR_READ_CFG   = 8'h22;
    localparam logic [IR_W-1:0] IR_PROG_SIG   = 8'h31;
    localparam logic [IR_W-1:0] IR_READ_SIG   = 8'h32;
    localparam logic [IR_W-1:0] IR_PROG_FUSE  = 8'h41;

    // identity value, arbitrary
    localparam logic [DR_W-1:0] ID_VALUE = 32'h0000_1001;

    // ------------------------------------------------------------------
    // sequencing counts
    // ------------------------------------------------------------------
    localparam logic [ID_CNT_W-1:0]  ID_RUN         = 3'h4;
    localparam logic [ID_CNT_W-1:0]  ID_LAST        = 3'h3;
    localparam logic [TMS_CNT_W-1:0] TMS_RESET_TCKS = 3'h5;
    localparam logic [TMS_CNT_W-1:0] TMS_CNT_MAX    = 3'h7;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
    localparam logic [ADDR_W-1:0] STAT_OFS = 12'h004;
    localparam logic [ADDR_W-1:0] SIG_OFS  = 12'h008;
    localparam logic [3:0]        CTRL_RESET = 4'hF;
    localparam int ST_ALT     = 0;
    localparam int ST_FUSE    = 1;
    localparam int ST_APS     = 2;
    localparam int ST_SEL     = 3;
    localparam int ST_CNT_LSB = 4;
    localparam int ST_TAP_LSB = 8;

    // ------------------------------------------------------------------
    // synchroniser bit positions
    // ------------------------------------------------------------------
    localparam int PIN_TCK  = 0;
    localparam int PIN_TMS  = 1;
    localparam int PIN_TDI  = 2;
    localparam int PIN_ALT  = 3;
    localparam int PIN_SEL  = 4;
    localparam int PIN_APS  = 5;
    localparam int PIN_USR  = 6;

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
    } tap_state_t;

endpackage : jtag_sel_pkg

// file: tap_ctrl.sv
`timescale 1ns/1ns
module tap_ctrl (
    input  wire logic              mclk,
    input  wire logic              resetn,
    input  wire logic              step,
    input  wire logic              tms,
    output jtag_sel_pkg::tap_state_t state_q
);
    import jtag_sel_pkg::*;

    // ------------------------------------------------------------------
    // sixteen-state walk, one move per test clock rise
    // ------------------------------------------------------------------
    function automatic tap_state_t nextState(input tap_state_t s,
                                             input logic m);
        case (s)
            TLR:     nextState = m ? TLR    : RTI;
            RTI:     nextState = m ? SEL_DR : RTI;
            SEL_DR:  nextState = m ? SEL_IR : CAP_DR;
            CAP_DR:  nextState = m ? EX1_DR : SH_DR;
            SH_DR:   nextState = m ? EX1_DR : SH_DR;
            EX1_DR:  nextState = m ? UPD_DR : PA_DR;
            PA_DR:   nextState = m ? EX2_DR : PA_DR;
            EX2_DR:  nextState = m ? UPD_DR : SH_DR;
            UPD_DR:  nextState = m ? SEL_DR : RTI;
            SEL_IR:  nextState = m ? TLR    : CAP_IR;
            CAP_IR:  nextState = m ? EX1_IR : SH_IR;
            SH_IR:   nextState = m ? EX1_IR : SH_IR;
            EX1_IR:  nextState = m ? UPD_IR : PA_IR;
            PA_IR:   nextState = m ? EX2_IR : PA_IR;
            EX2_IR:  nextState = m ? UPD_IR : SH_IR;
            UPD_IR:  nextState = m ? SEL_DR : RTI;
            default: nextState = TLR;
        endcase
    endfunction : nextState

    // power-on state is the reset state of the test logic
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_q <= TLR;
        end else if (step) begin
            state_q <= nextState(state_q, tms);
        end
    end

    a_tlr_holds: assert property (
        @(posedge mclk) disable iff (!resetn)
        (state_q == TLR && step && tms) |=> (state_q == TLR))
        else $error("tap left reset state with mode high");

endmodule : tap_ctrl

// file: jtag_alt_input_select.sv
// What this block does
// - select pin pulled up; high with no latch means normal input feeds logic
// - select pin low: alternate input used, normal input ignored, any state
// - four consecutive identity loads at Update-IR switch to alternate input
// - alternate selection holds until Test-Logic-Reset restores normal input
// - entering Test-Logic-Reset loads the identity instruction automatically
// - programming-supply-only: all non-test digital outputs go high impedance
// - programming-supply-only: FET-mode high-voltage outputs low, inputs ignored
// - configuration programmed over the four-wire test port, held non-volatile
// - programmed security fuse blocks configuration readout through the port
// - security fuse cleared only by bulk erase during reprogramming
// - 32-bit user signature word held and readable through the test port
// - data and mode sampled on clock rise, serial output changes on fall
// - mode held high reaches reset state within five clocks; power-on state
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ns
module jtag_alt_input_select #(
    parameter int NUM_IN  = 4,
    parameter int NUM_OUT = 8,
    parameter int NUM_HV  = 4
) (
    input  wire logic                        mclk,
    input  wire logic                        resetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [jtag_sel_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        tck,
    input  wire logic                        tms,
    input  wire logic                        tdi,
    input  wire logic                        alternateSerialInput,
    input  wire logic                        inputSelectPin,
    input  wire logic                        programmingSupplyPin,
    output logic                             tdo,
    output logic                             tdoEn,
    input  wire logic [NUM_IN-1:0]           userIn,
    output logic      [NUM_IN-1:0]           coreIn,
    input  wire logic [NUM_OUT-1:0]          coreOut,
    output logic      [NUM_OUT-1:0]          digOut,
    output logic      [NUM_OUT-1:0]          digOutEn,
    input  wire logic [NUM_HV-1:0]           hvDrive,
    output logic      [NUM_HV-1:0]           highVoltageOutput,
    output logic      [NUM_HV-1:0]           highVoltageOutputEn
);
    import jtag_sel_pkg::*;

    localparam int SYNC_W = PIN_USR + NUM_IN;
    // select pin idles high like its pull-up
    localparam logic [SYNC_W-1:0] SYNC_RST = SYNC_W'(1) << PIN_SEL;

    logic [SYNC_W-1:0]   syncA_q;
    logic [SYNC_W-1:0]   syncB_q;
    logic                tckPrev_q;
    tap_state_t          tapState;
    logic [IR_W-1:0]     irShift_q;
    logic [IR_W-1:0]     ir_q;
    logic [DR_W-1:0]     dr_q;
    logic                byp_q;
    logic                pending_q;
    logic [ID_CNT_W-1:0] idCount_q;
    logic                altSel_q;
    logic [DR_W-1:0]     cfg_q;
    logic [DR_W-1:0]     userSignatureWord_q;
    logic                securityFuseBit_q;
    logic [3:0]          hvFet_q;
    logic [31:0]         prdata_q;
    logic                tdo_q;
    logic                tdoEn_q;
    logic [TMS_CNT_W-1:0] tmsHighCnt_q;
    logic                tckRise;
    logic                tckFall;
    logic                tmsS;
    logic                selHigh;
    logic                apsOn;
    logic                altActive;
    logic                activeIn;
    logic                commit;
    logic                eraseEvt;

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    function automatic logic usesDr(input logic [IR_W-1:0] ins);
        usesDr = (ins == IR_IDCODE) || (ins == IR_PROG_CFG) ||
                 (ins == IR_READ_CFG) || (ins == IR_PROG_SIG) ||
                 (ins == IR_READ_SIG);
    endfunction : usesDr

    function automatic logic regMapped(input logic [ADDR_W-1:0] a);
        regMapped = (a == CTRL_OFS) || (a == STAT_OFS) || (a == SIG_OFS);
    endfunction : regMapped

    // ------------------------------------------------------------------
    // pin synchronisers and test clock edges
    // ------------------------------------------------------------------
    // every pin crosses two flops before anything looks at it
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            syncA_q   <= SYNC_RST;
            syncB_q   <= SYNC_RST;
            tckPrev_q <= 1'b0;
        end else begin
            syncA_q   <= {userIn, programmingSupplyPin, inputSelectPin,
                          alternateSerialInput, tdi, tms, tck};
            syncB_q   <= syncA_q;
            tckPrev_q <= syncB_q[PIN_TCK];
        end
    end

    assign tckRise = syncB_q[PIN_TCK] & ~tckPrev_q;
    assign tckFall = ~syncB_q[PIN_TCK] & tckPrev_q;
    assign tmsS    = syncB_q[PIN_TMS];
    assign selHigh = syncB_q[PIN_SEL];
    assign apsOn   = syncB_q[PIN_APS];

    // low select pin forces the alternate path in every state
    assign altActive = ~selHigh | altSel_q;
    assign activeIn  = altActive ? syncB_q[PIN_ALT]
                                 : syncB_q[PIN_TDI];

    tap_ctrl u_tap (
        .mclk    (mclk),
        .resetn  (resetn),
        .step    (tckRise),
        .tms     (tmsS),
        .state_q (tapState)
    );

    // ------------------------------------------------------------------
    // instruction register
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            irShift_q <= IR_IDCODE;
            ir_q      <= IR_IDCODE;
        end else if (tapState == TLR) begin
            ir_q <= IR_IDCODE;
        end else if (tckRise) begin
            case (tapState)
                CAP_IR:  irShift_q <= IR_IDCODE;
                SH_IR:   irShift_q <= {activeIn, irShift_q[IR_W-1:1]};
                UPD_IR:  ir_q      <= irShift_q;
                default: irShift_q <= irShift_q;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // alternate input latch, fed by a run of identity loads
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            idCount_q <= '0;
            altSel_q  <= 1'b0;
        end else if (tapState == TLR) begin
            idCount_q <= '0;
            altSel_q  <= 1'b0;
        end else if (tckRise && tapState == UPD_IR) begin
            if (irShift_q == IR_IDCODE) begin
                if (idCount_q != ID_RUN) begin
                    idCount_q <= idCount_q + ID_CNT_W'(1);
                end
                if (idCount_q == ID_LAST && selHigh) begin
                    altSel_q <= 1'b1;
                end
            end else begin
                idCount_q <= '0;
            end
        end
    end

    // ------------------------------------------------------------------
    // data registers, shifted on the test clock rise
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            dr_q  <= '0;
            byp_q <= 1'b0;
        end else if (tckRise) begin
            case (tapState)
                CAP_DR: begin
                    byp_q <= 1'b0;
                    case (ir_q)
                        IR_IDCODE:   dr_q <= ID_VALUE;
                        // locked parts hand back zeros, never the pattern
                        IR_READ_CFG: dr_q <= securityFuseBit_q ? '0
                                                               : cfg_q;
                        IR_READ_SIG: dr_q <= userSignatureWord_q;
                        default:     dr_q <= '0;
                    endcase
                end
                SH_DR: begin
                    dr_q  <= {activeIn, dr_q[DR_W-1:1]};
                    byp_q <= activeIn;
                end
                default: dr_q <= dr_q;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // non-volatile store, written on the first test clock rise spent in idle after an update
    // ------------------------------------------------------------------
    assign commit   = tckRise && tapState == RTI && pending_q;
    assign eraseEvt = commit && ir_q == IR_BULK_ERASE;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pending_q <= 1'b0;
        end else if (tapState == TLR || commit) begin
            pending_q <= 1'b0;
        end else if (tckRise && (tapState == UPD_IR || tapState == UPD_DR)) begin
            pending_q <= 1'b1;
        end
    end

    // resetn stands in for power-up; the cells start erased
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cfg_q               <= '0;
            userSignatureWord_q <= '0;
            securityFuseBit_q   <= 1'b0;
        end else if (commit) begin
            case (ir_q)
                IR_PROG_CFG:   cfg_q <= dr_q;
                IR_PROG_SIG:   userSignatureWord_q <= dr_q;
                IR_PROG_FUSE:  securityFuseBit_q <= 1'b1;
                IR_BULK_ERASE: begin
                    cfg_q               <= '0;
                    userSignatureWord_q <= '0;
                    securityFuseBit_q   <= 1'b0;
                end
                default:       cfg_q <= cfg_q;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // serial output, moved only on the test clock fall
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tdo_q   <= 1'b0;
            tdoEn_q <= 1'b0;
        end else if (tckFall) begin
            tdoEn_q <= (tapState == SH_IR) || (tapState == SH_DR);
            if (tapState == SH_IR) begin
                tdo_q <= irShift_q[0];
            end else if (usesDr(ir_q)) begin
                tdo_q <= dr_q[0];
            end else begin
                tdo_q <= byp_q;
            end
        end
    end

    assign tdo   = tdo_q;
    assign tdoEn = tdoEn_q;

    // ------------------------------------------------------------------
    // core pins while only the programming supply is up
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            coreIn   <= '0;
            digOut   <= '0;
            digOutEn <= '0;
        end else begin
            coreIn   <= apsOn ? '0 : syncB_q[PIN_USR +: NUM_IN];
            digOut   <= coreOut;
            digOutEn <= apsOn ? '0 : '1;
        end
    end

    // FET drivers clamp low; plain digital ones float with the rest
    for (genvar h = 0; h < NUM_HV; h++) begin : g_hv
        logic fetMode;
        assign fetMode = (h < 4) ? hvFet_q[h % 4] : 1'b0;
        always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
                highVoltageOutput[h]   <= 1'b0;
                highVoltageOutputEn[h] <= 1'b0;
            end else begin
                highVoltageOutput[h]   <= apsOn ? 1'b0 : hvDrive[h];
                highVoltageOutputEn[h] <= apsOn ? fetMode : 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------------
    // read data is fetched in setup so the access phase needs no wait
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            prdata_q <= '0;
        end else if (psel && !penable) begin
            case (paddr)
                CTRL_OFS: prdata_q <= {28'h0000000, hvFet_q};
                STAT_OFS: begin
                    prdata_q                   <= '0;
                    prdata_q[ST_ALT]           <= altActive;
                    prdata_q[ST_FUSE]          <= securityFuseBit_q;
                    prdata_q[ST_APS]           <= apsOn;
                    prdata_q[ST_SEL]           <= selHigh;
                    prdata_q[ST_CNT_LSB +: ID_CNT_W] <= idCount_q;
                    prdata_q[ST_TAP_LSB +: 4]  <= tapState;
                end
                SIG_OFS:  prdata_q <= userSignatureWord_q;
                default:  prdata_q <= '0;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            hvFet_q <= CTRL_RESET;
        end else if (psel && penable && pwrite && paddr == CTRL_OFS) begin
            hvFet_q <= pwdata[3:0];
        end
    end

    assign prdata  = prdata_q;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !regMapped(paddr);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tmsHighCnt_q <= '0;
        end else if (tckRise) begin
            if (!tmsS) begin
                tmsHighCnt_q <= '0;
            end else if (tmsHighCnt_q != TMS_CNT_MAX) begin
                tmsHighCnt_q <= tmsHighCnt_q + TMS_CNT_W'(1);
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence fourthIdLoad;
        tckRise && tapState == UPD_IR && irShift_q == IR_IDCODE &&
        idCount_q == ID_LAST && selHigh;
    endsequence

    sequence otherLoad;
        tckRise && tapState == UPD_IR && irShift_q != IR_IDCODE;
    endsequence

    a_normal_input: assert property (
        (selHigh && !altSel_q) |-> (activeIn == syncB_q[PIN_TDI]))
        else $error("normal input not selected");
    a_pin_low_alt: assert property (
        !selHigh |-> (activeIn == syncB_q[PIN_ALT]))
        else $error("alternate input not used with select low");
    a_four_loads_alt: assert property (
        fourthIdLoad |=> altSel_q ##1 altActive)
        else $error("alternate not latched after fourth identity load");
    a_reset_restores: assert property (
        (tapState == TLR) |=> !altSel_q)
        else $error("alternate latch survived reset state");
    a_ir_idcode_tlr: assert property (
        (tapState == TLR) |=> (ir_q == IR_IDCODE))
        else $error("identity instruction not loaded in reset state");
    a_aps_outputs_hiz: assert property (
        $rose(apsOn) |=> (digOutEn == '0) && (coreIn == '0))
        else $error("outputs driven on programming supply");
    a_aps_hv_low: assert property (
        apsOn |=> (highVoltageOutput == '0))
        else $error("high-voltage output not low on programming supply");
    a_fuse_blocks_read: assert property (
        (tckRise && tapState == CAP_DR && ir_q == IR_READ_CFG &&
         securityFuseBit_q) |=> (dr_q == '0))
        else $error("configuration readable with fuse set");
    a_fuse_only_erase: assert property (
        (securityFuseBit_q && !eraseEvt) |=> securityFuseBit_q)
        else $error("fuse cleared without erase");
    a_count_clears: assert property (
        otherLoad |=> (idCount_q == '0))
        else $error("identity count kept after other instruction");
    a_tms_five_reset: assert property (
        (tmsHighCnt_q >= TMS_RESET_TCKS) |-> (tapState == TLR))
        else $error("reset state not reached within five clocks");
    a_tdo_on_fall: assert property (
        $changed(tdo_q) |-> $past(tckFall))
        else $error("serial output moved outside clock fall");

endmodule : jtag_alt_input_select

// file: jtag_host.sv
`timescale 1ns/1ns
// ----
// test-port host model
// ----
module jtag_host (
    input  wire logic mclk,
    input  wire logic tdo,
    output logic      tck,
    output logic      tms,
    output logic      tdi
);
    logic tdoS;
    // clock rests low between frames, so idle time shows no edges
    initial begin
        tck = 0;
        tms = 1;
        tdi = 0;
    end
    // one 160 ns period; tdo taken well after the fall
    // mode and data lead the rise by two cycles so both are synced first
    task step(input logic m, input logic d);
        @(posedge mclk);
        tms <= m;
        tdi <= d;
        repeat (2) @(posedge mclk);
        tck <= 1;
        repeat (8) @(posedge mclk);
        tck <= 0;
        repeat (5) @(posedge mclk);
        tdoS = tdo;
    endtask : step
    // mode high for five clocks, then into idle
    task idle();
        repeat (5) step(1, 0);
        step(0, 0);
    endtask : idle
    // from idle: shift n bits lsb first, update, one idle rise commits
    task scan(input logic ir, input logic [31:0] v, input int n,
              output logic [31:0] o);
        o = '0;
        step(1, 0);
        if (ir) step(1, 0);
        step(0, 0);
        step(0, 0);
        for (int i = 0; i < n; i++) begin
            o[i] = tdoS;
            step(i == n - 1, v[i]);
        end
        step(1, 0);
        step(0, 0);
        step(0, 0);
    endtask : scan
endmodule : jtag_host

// file: jtag_alt_input_select_tb.sv
`timescale 1ns/1ns
module jtag_alt_input_select_tb;
    import jtag_sel_pkg::*;
    logic mclk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic tck, tms, hostTdi, tdo, tdoEn, pready, pslverr, err;
    logic sel = 1, programming_supply_pin = 0, route = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, sh;
    logic [3:0]  userIn = 4'hA, coreIn, hvDrive = 4'h9, hv, hvEn;
    logic [7:0]  coreOut = 8'h5A, digOut, digOutEn;
    int error_cnt = 0, checked = 0, cyc = 0;
    // ----
    // clock, watchdog, instances
    // ----
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            test_done();
        end
    end
    // the unused data pin carries the inverse, so a wrong pick shows
    jtag_alt_input_select u_dut (.mclk, .resetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .tck, .tms,
        .tdi(route ? ~hostTdi : hostTdi),
        .alternateSerialInput(route ? hostTdi : ~hostTdi),
        .inputSelectPin(sel), .programmingSupplyPin(programming_supply_pin), .tdo, .tdoEn,
        .userIn, .coreIn, .coreOut, .digOut, .digOutEn, .hvDrive,
        .highVoltageOutput(hv), .highVoltageOutputEn(hvEn));
    jtag_host u_host (.mclk, .tdo, .tck, .tms, .tdi(hostTdi));
    // ----
    // tasks
    // ----
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1;
        // no cycle count assumed; only the watchdog ends a stuck wait
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", s, e, g);
            error_cnt++;
        end
    endtask : chk
    task op(input logic [7:0] c, input logic [31:0] d, input logic dr);
        u_host.scan(1, c, 8, sh);
        if (dr) u_host.scan(0, d, 32, sh);
    endtask : op
    task test_done();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : test_done
    // ----
    // tests
    // ----
    initial begin
        repeat (5) @(posedge mclk);
        resetn <= 1;
        repeat (4) @(posedge mclk);
        apb(0, STAT_OFS, 0);
        chk("status", 32'h8, rd);
        apb(0, CTRL_OFS, 0);
        chk("ctrl", 32'hF, rd);
        apb(0, 12'h0FC, 0);
        chk("unmapped", 32'h1, {rd[30:0], err});
        u_host.idle();
        u_host.scan(0, 0, 32, sh);
        chk("idcode", ID_VALUE, sh);
        chk("tdo enable", 32'h0, tdoEn);
        $display("test reset done");
        repeat (3) op(IR_IDCODE, 0, 0);
        chk("captured ir", IR_IDCODE, sh);
        // a count left over from before reset would latch too early
        u_host.idle();
        apb(0, STAT_OFS, 0);
        chk("status", 32'h108, rd);
        repeat (2) op(IR_IDCODE, 0, 0);
        op(IR_BYPASS, 0, 0);
        apb(0, STAT_OFS, 0);
        chk("status", 32'h108, rd);
        repeat (4) op(IR_IDCODE, 0, 0);
        apb(0, STAT_OFS, 0);
        chk("status", 32'h149, rd);
        route <= 1;
        op(IR_PROG_SIG, 32'hA5C3_0F96, 1);
        apb(0, SIG_OFS, 0);
        chk("signature", 32'hA5C3_0F96, rd);
        op(IR_READ_SIG, 0, 1);
        chk("signature scan", 32'hA5C3_0F96, sh);
        u_host.idle();
        route <= 0;
        apb(0, STAT_OFS, 0);
        chk("status", 32'h108, rd);
        $display("test sequence select done");
        sel <= 0;
        route <= 1;
        op(IR_PROG_SIG, 32'h3C96_5AA5, 1);
        apb(0, SIG_OFS, 0);
        chk("signature", 32'h3C96_5AA5, rd);
        // low pin makes the alternate input active, so bit 0 reads set
        apb(0, STAT_OFS, 0);
        chk("status", 32'h101, rd);
        sel <= 1;
        route <= 0;
        $display("test pin select done");
        op(IR_PROG_CFG, 32'h1234_5678, 1);
        op(IR_READ_CFG, 0, 1);
        chk("config", 32'h1234_5678, sh);
        op(IR_PROG_FUSE, 0, 0);
        op(IR_READ_CFG, 0, 1);
        chk("config", 32'h0, sh);
        u_host.idle();
        apb(0, STAT_OFS, 0);
        chk("status", 32'h10A, rd);
        op(IR_BULK_ERASE, 0, 0);
        apb(0, STAT_OFS, 0);
        chk("status", 32'h108, rd);
        apb(0, SIG_OFS, 0);
        chk("signature", 32'h0, rd);
        $display("test fuse done");
        programming_supply_pin <= 1;
        apb(1, CTRL_OFS, 32'h5);
        repeat (6) @(posedge mclk);
        chk("dig enable", 32'h0, digOutEn);
        chk("hv out", 32'h0, {hv, coreIn});
        chk("hv enable", 32'h5, hvEn);
        programming_supply_pin <= 0;
        repeat (6) @(posedge mclk);
        chk("dig", 32'hFF5A, {digOutEn, digOut});
        chk("hv in", 32'hF9A, {hvEn, hv, coreIn});
        $display("test supply done");
        test_done();
    end
endmodule : jtag_alt_input_select_tb
